/* sup_pkg.sv */
// package: timing constants, threshold figures and output reset values for the supervisor
package sup_pkg;
  // clock rate
  localparam int unsigned CLK_HZ          = 50_000_000;
  // reset stretch period in ms, watchdog timeout in ms, debounce in ns
  localparam int unsigned RESET_STRETCH_MS = 200;
  localparam int unsigned WDOG_TIMEOUT_MS  = 1600;
  localparam int unsigned DEBOUNCE_NS      = 500;
  // derived cycle counts (longest-time figures round down, least round up)
  localparam longint unsigned RESET_STRETCH_CYC =
    longint'(RESET_STRETCH_MS) * CLK_HZ / 1000;
  localparam longint unsigned WDOG_TIMEOUT_CYC =
    longint'(WDOG_TIMEOUT_MS) * CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_CYC =
    (DEBOUNCE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // supply threshold variants in millivolts, kept for documentation of straps
  localparam int unsigned THRESH_R_MV = 2630;
  localparam int unsigned THRESH_S_MV = 2930;
  localparam int unsigned THRESH_T_MV = 3080;
  // power-fail reference in millivolts
  localparam int unsigned PFAIL_REF_MV = 1250;
  // reset values of the outputs
  localparam logic RESET_N_INIT  = 1'b0;
  localparam logic WDOG_N_INIT   = 1'b0;
  localparam logic PFAIL_N_INIT  = 1'b0;
endpackage

/* sync_filter.sv */
// three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
module sync_filter (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      level_out
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // s1 is read only by s2; level updates once s2 and s3 agree
  always_ff @(posedge mclk) begin
    if (reset) begin
      s1_r      <= 1'b1;
      s2_r      <= 1'b1;
      s3_r      <= 1'b1;
      level_out <= 1'b1;
    end else if (clk_en) begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_out <= s3_r;
      end
    end
  end
endmodule

/* supervisory_reset_watchdog.sv */
// supervisor: reset combiner and stretcher, watchdog, power-fail flag
// ***************************************************************
// Notes on behaviour
// - all reset outputs asserted while manual reset request is low.
// - manual reset request is debounced before it acts.
// - supply-low asserts reset; threshold is a 2.63/2.93/3.08 V variant.
// - reset held one 200 ms period after last of supply-low and manual clear.
// - every edge of the kick input restarts the watchdog timer.
// - watchdog output low once kick stays still beyond 1.6 s.
// - watchdog output low during supply-low, until supply valid again.
// - watchdog never asserts reset itself; only via external loopback.
// - watchdog disable input clears the timer to zero, never times out.
// - active-high reset is exact complement of active-low reset.
// - power-fail flag high when sense is above reference, else low.
// - power-fail flag independent of reset, manual reset, watchdog.
// ***************************************************************
`timescale 1ns/1ps
module supervisory_reset_watchdog #(
  parameter longint unsigned STRETCH_CYC  = sup_pkg::RESET_STRETCH_CYC,
  parameter longint unsigned WDOG_CYC     = sup_pkg::WDOG_TIMEOUT_CYC,
  parameter int unsigned     DEBOUNCE_CYC = sup_pkg::DEBOUNCE_CYC,
  parameter bit              SINGLE_HIGH  = 1'b0
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic supply_low,
  input  wire logic manual_reset_req_n,
  input  wire logic wdog_kick_in,
  input  wire logic wdog_disable,
  input  wire logic powerfail_sense_in,
  output logic      reset_out_n,
  output logic      reset_out,
  output logic      wdog_timeout_n,
  output logic      powerfail_flag_n
);
  // ***************************************************************
  // input conditioning
  // ***************************************************************
  localparam int SW = 32;
  localparam int DW = 16;

  // last cycle of a count; widened so a 64-bit limit is never truncated
  function automatic logic at_limit(input logic [SW-1:0] cnt,
                                    input longint unsigned lim);
    return 64'(cnt) >= lim - 64'd1;
  endfunction

  logic          mr_sync;
  logic          kick_sync;
  logic          pf_sync;
  logic          dis_sync;
  logic          low_sync;
  logic          mr_deb_r;
  logic [DW-1:0] deb_cnt_r;
  logic [DW-1:0] deb_cnt_nxt;
  logic          kick_prev_r;
  logic [SW-1:0] str_cnt_r;
  logic [SW-1:0] str_cnt_nxt;
  logic [SW-1:0] wd_cnt_r;
  logic [SW-1:0] wd_cnt_nxt;
  logic          wd_expired_r;
  wire           kick_edge;
  wire           hold_reset;
  wire           stretch_done;
  wire           rst_assert_nxt;
  wire           wd_low_nxt;

  sync_filter u_mr (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  (manual_reset_req_n),
    .level_out (mr_sync)
  );
  sync_filter u_kick (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  (wdog_kick_in),
    .level_out (kick_sync)
  );
  sync_filter u_pf (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  (powerfail_sense_in),
    .level_out (pf_sync)
  );
  sync_filter u_dis (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  (wdog_disable),
    .level_out (dis_sync)
  );
  // supply-low from analog side; treat as asynchronous too
  sync_filter u_low (
    .mclk      (mclk),
    .reset     (reset),
    .clk_en    (clk_en),
    .async_in  (~supply_low),
    .level_out (low_sync)
  );

  // ***************************************************************
  // debounce of the manual reset request
  // ***************************************************************
  // the filtered level must differ for DEBOUNCE_CYC cycles to be taken
  assign deb_cnt_nxt = (mr_sync == mr_deb_r) ? '0 :
                       deb_cnt_r + 1'b1;

  // supply-low clear sits under the enable so a frozen block stays frozen
  always_ff @(posedge mclk) begin
    if (reset) begin
      deb_cnt_r <= '0;
      mr_deb_r  <= 1'b0;
    end else if (clk_en) begin
      if (!low_sync) begin
        deb_cnt_r <= '0;
        mr_deb_r  <= 1'b0;
      end else if (32'(deb_cnt_nxt) >= DEBOUNCE_CYC) begin
        mr_deb_r  <= mr_sync;
        deb_cnt_r <= '0;
      end else begin
        deb_cnt_r <= deb_cnt_nxt;
      end
    end
  end

  // ***************************************************************
  // reset combine and stretch
  // ***************************************************************
  // low_sync is 1 when supply is valid; mr_deb_r low holds reset
  assign hold_reset   = !low_sync || !mr_deb_r;
  assign stretch_done = at_limit(str_cnt_r, STRETCH_CYC);
  assign str_cnt_nxt  = hold_reset ? '0 :
                        (stretch_done ? str_cnt_r : str_cnt_r + 1'b1);
  // counting restarts from zero whenever either source is active
  assign rst_assert_nxt = hold_reset || !stretch_done;

  always_ff @(posedge mclk) begin
    if (reset) begin
      str_cnt_r   <= '0;
      reset_out_n <= sup_pkg::RESET_N_INIT;
      reset_out   <= ~sup_pkg::RESET_N_INIT;
    end else if (clk_en) begin
      str_cnt_r   <= str_cnt_nxt;
      reset_out_n <= ~rst_assert_nxt;
      reset_out   <= rst_assert_nxt;
    end
  end

  // ***************************************************************
  // watchdog
  // ***************************************************************
  // edge detect looks at the filtered level, never the first stage
  assign kick_edge = kick_sync ^ kick_prev_r;
  assign wd_cnt_nxt = (kick_edge || dis_sync) ? '0 :
                      (wd_expired_r ? wd_cnt_r : wd_cnt_r + 1'b1);
  // watchdog only drives its own pin; reset needs external loopback
  assign wd_low_nxt = !low_sync || (wd_expired_r && !kick_edge
                      && !dis_sync);

  always_ff @(posedge mclk) begin
    if (reset) begin
      wd_cnt_r     <= '0;
      wd_expired_r <= 1'b0;
      kick_prev_r  <= kick_sync;
    end else if (clk_en) begin
      kick_prev_r  <= kick_sync;
      if (!low_sync) begin
        wd_cnt_r     <= '0;
        wd_expired_r <= 1'b0;
      end else begin
        wd_cnt_r     <= wd_cnt_nxt;
        wd_expired_r <= !kick_edge && !dis_sync &&
                        (wd_expired_r || at_limit(wd_cnt_r, WDOG_CYC));
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      wdog_timeout_n <= sup_pkg::WDOG_N_INIT;
    end else if (clk_en) begin
      wdog_timeout_n <= ~wd_low_nxt;
    end
  end

  // ***************************************************************
  // power-fail flag, touches nothing else
  // ***************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      powerfail_flag_n <= sup_pkg::PFAIL_N_INIT;
    end else if (clk_en) begin
      powerfail_flag_n <= pf_sync;
    end
  end

  // ***************************************************************
  // assertions
  // ***************************************************************
  property p_complement;
    @(posedge mclk) disable iff (reset) reset_out == ~reset_out_n;
  endproperty
  a_complement: assert property (p_complement)
    else $error("reset outputs not complementary");

  property p_mr_holds;
    @(posedge mclk) disable iff (reset)
      (clk_en && !mr_deb_r) |=> !reset_out_n;
  endproperty
  a_mr_holds: assert property (p_mr_holds)
    else $error("reset released during manual request");

  property p_low_holds;
    @(posedge mclk) disable iff (reset)
      (clk_en && !low_sync) |=> (!reset_out_n && !wdog_timeout_n);
  endproperty
  a_low_holds: assert property (p_low_holds)
    else $error("supply-low did not hold outputs low");

  property p_stretch;
    @(posedge mclk) disable iff (reset)
      (clk_en && hold_reset) ##1 (clk_en && !hold_reset) |=> !reset_out_n;
  endproperty
  a_stretch: assert property (p_stretch)
    else $error("reset released without stretch");

  property p_kick_restart;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && kick_edge) |=> (wd_cnt_r == '0);
  endproperty
  a_kick_restart: assert property (p_kick_restart)
    else $error("kick did not restart watchdog");

  property p_disable;
    @(posedge mclk) disable iff (reset)
      (clk_en && dis_sync && low_sync) |=> wdog_timeout_n;
  endproperty
  a_disable: assert property (p_disable)
    else $error("watchdog fired while disabled");

  property p_pfail;
    @(posedge mclk) disable iff (reset)
      clk_en |=> (powerfail_flag_n == $past(pf_sync));
  endproperty
  a_pfail: assert property (p_pfail)
    else $error("power-fail flag does not follow sense");

  property p_wd_no_reset;
    @(posedge mclk) disable iff (reset)
      (clk_en && !hold_reset && stretch_done) |=> reset_out_n;
  endproperty
  a_wd_no_reset: assert property (p_wd_no_reset)
    else $error("reset asserted without a reset source");

  property p_wd_fire;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && wd_expired_r && !kick_edge && !dis_sync)
        |=> !wdog_timeout_n;
  endproperty
  a_wd_fire: assert property (p_wd_fire)
    else $error("watchdog expired but output stayed high");

  property p_wd_quiet;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && !wd_expired_r) |=> wdog_timeout_n;
  endproperty
  a_wd_quiet: assert property (p_wd_quiet)
    else $error("watchdog output low before timeout");

  property p_kick_clears;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && kick_edge)
        |=> (wdog_timeout_n && !wd_expired_r);
  endproperty
  a_kick_clears: assert property (p_kick_clears)
    else $error("kick did not clear watchdog timeout");

  property p_dis_clears;
    @(posedge mclk) disable iff (reset)
      (clk_en && dis_sync) |=> !wd_expired_r;
  endproperty
  a_dis_clears: assert property (p_dis_clears)
    else $error("watchdog expired while disabled");

  property p_deb_reject;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && mr_sync == mr_deb_r) |=> $stable(mr_deb_r);
  endproperty
  a_deb_reject: assert property (p_deb_reject)
    else $error("debounced level moved without input change");

  property p_deb_take;
    @(posedge mclk) disable iff (reset)
      (clk_en && low_sync && mr_sync != mr_deb_r &&
       32'(deb_cnt_r) + 32'd1 >= DEBOUNCE_CYC)
        |=> (mr_deb_r == $past(mr_sync));
  endproperty
  a_deb_take: assert property (p_deb_take)
    else $error("debounced level not taken after interval");

  property p_low_counters;
    @(posedge mclk) disable iff (reset)
      (clk_en && !low_sync)
        |=> (deb_cnt_r == '0 && wd_cnt_r == '0 && str_cnt_r == '0);
  endproperty
  a_low_counters: assert property (p_low_counters)
    else $error("counter not cleared during supply-low");

  property p_reset_high;
    @(posedge mclk) disable iff (reset)
      (clk_en && hold_reset) |=> reset_out;
  endproperty
  a_reset_high: assert property (p_reset_high)
    else $error("active-high reset low while a source holds");
endmodule

/* proc_model.sv */
// processor model: toggles the watchdog kick while its program runs
`timescale 1ns/1ps
module proc_model #(
  parameter int HALF = 50
) (
  input  wire logic mclk,
  input  wire logic run,
  output logic      wdog_kick_in
);
  int   cnt_r  = 0;
  logic kick_r = 1'b0;

  assign wdog_kick_in = kick_r;

  // a stalled program stops kicking, which is how a hang shows up;
  // acting on the rising edge keeps it clear of bench stimulus
  always @(posedge mclk) begin
    if (run) begin
      cnt_r <= (cnt_r == HALF - 1) ? 0 : cnt_r + 1;
      if (cnt_r == HALF - 1) kick_r <= ~kick_r;
    end
  end
endmodule

/* tb.sv */
// testbench: supervisor scenarios against a processor model
`timescale 1ns/1ps
module tb;
  // ***************************************************************
  // shortened periods keep the run to about a thousand cycles
  // ***************************************************************
  localparam int STR = 50;
  localparam int WDG = 200;
  logic mclk, reset, clk_en, supply_low, manual_reset_req_n;
  logic wdog_disable, powerfail_sense_in, run, wdog_kick_in;
  logic reset_out_n, reset_out, wdog_timeout_n, powerfail_flag_n;
  int   errors, tests_run;

  supervisory_reset_watchdog #(.STRETCH_CYC(STR), .WDOG_CYC(WDG),
    .DEBOUNCE_CYC(4)) supervisory_reset_watchdog_inst (
    .mclk(mclk), .reset(reset), .clk_en(clk_en),
    .supply_low(supply_low), .manual_reset_req_n(manual_reset_req_n),
    .wdog_kick_in(wdog_kick_in), .wdog_disable(wdog_disable),
    .powerfail_sense_in(powerfail_sense_in), .reset_out_n(reset_out_n),
    .reset_out(reset_out), .wdog_timeout_n(wdog_timeout_n),
    .powerfail_flag_n(powerfail_flag_n));

  proc_model #(.HALF(50)) proc_model_inst (
    .mclk(mclk), .run(run), .wdog_kick_in(wdog_kick_in));

  // free-running clock, 20 ns period
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // both reset pins at once, so the complement is checked every time
  task chk_rst(input logic exp_n);
    chk(reset_out_n, exp_n);
    chk(reset_out, ~exp_n);
  endtask

  task end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task t_stretch;
    cyc(STR - 5);
    chk_rst(1'h0);
    cyc(20);
    chk_rst(1'h1);
  endtask

  // power-fail is moved while reset is active to show independence
  task t_manual;
    manual_reset_req_n = 1'h0;
    cyc(2);
    manual_reset_req_n = 1'h1;
    cyc(12);
    chk_rst(1'h1);
    manual_reset_req_n = 1'h0;
    powerfail_sense_in = 1'h0;
    cyc(12);
    chk_rst(1'h0);
    chk(powerfail_flag_n, 1'h0);
    cyc(40);
    manual_reset_req_n = 1'h1;
    cyc(STR - 5);
    chk_rst(1'h0);
    chk(powerfail_flag_n, 1'h0);
    powerfail_sense_in = 1'h1;
    cyc(8);
    chk(powerfail_flag_n, 1'h1);
    cyc(20);
    chk_rst(1'h1);
  endtask

  // last kick may be up to one half period before the stall
  task t_wdog;
    run = 1'h0;
    cyc(140);
    chk(wdog_timeout_n, 1'h1);
    cyc(130);
    chk(wdog_timeout_n, 1'h0);
    chk_rst(1'h1);
    run = 1'h1;
    cyc(62);
    chk(wdog_timeout_n, 1'h1);
  endtask

  task t_disable;
    wdog_disable = 1'h1;
    run = 1'h0;
    cyc(300);
    chk(wdog_timeout_n, 1'h1);
    wdog_disable = 1'h0;
    run = 1'h1;
    cyc(20);
  endtask

  task t_supply;
    supply_low = 1'h1;
    cyc(8);
    chk_rst(1'h0);
    chk(powerfail_flag_n, 1'h1);
    cyc(30);
    chk(wdog_timeout_n, 1'h0);
    supply_low = 1'h0;
    cyc(STR - 5);
    chk_rst(1'h0);
    cyc(20);
    chk_rst(1'h1);
    chk(wdog_timeout_n, 1'h1);
  endtask

  // enable low freezes every supervisor flop; changes land only once it returns
  task t_freeze;
    clk_en = 1'h0;
    powerfail_sense_in = 1'h0;
    supply_low = 1'h1;
    cyc(20);
    chk(powerfail_flag_n, 1'h1);
    chk_rst(1'h1);
    clk_en = 1'h1;
    cyc(8);
    chk(powerfail_flag_n, 1'h0);
    chk_rst(1'h0);
    powerfail_sense_in = 1'h1;
    supply_low = 1'h0;
    cyc(STR + 20);
    chk_rst(1'h1);
    chk(powerfail_flag_n, 1'h1);
  endtask

  // main sequence; inputs change on the falling edge only
  initial begin
    errors = 0;
    tests_run = 0;
    reset = 1'h1;
    clk_en = 1'h1;
    supply_low = 1'h0;
    manual_reset_req_n = 1'h1;
    wdog_disable = 1'h0;
    powerfail_sense_in = 1'h1;
    run = 1'h1;
    cyc(16);
    reset = 1'h0;
    t_stretch();
    t_manual();
    t_wdog();
    t_disable();
    t_supply();
    t_freeze();
    end_of_test();
  end

  // hang guard, several times the expected run length
  initial begin
    #200_000;
    errors++;
    end_of_test();
  end
endmodule
